//--- src/xck_align_chk.v
// Alignment checker for data and control-transfer target addresses
`timescale 1ns/100ps
`include "xck_defs.vh"
module xck_align_chk (
    input  wire [1:0] data_addr_lo,
    input  wire [1:0] data_size,
    input  wire       data_valid,
    input  wire [1:0] target_lo,
    input  wire       target_valid,
    output wire       data_misaligned,
    output wire       target_misaligned
);
    // Word needs both low bits clear, half needs bit 0 clear, byte never faults
    assign data_misaligned = data_valid &&
        (((data_size == `XCK_SZ_WORD) && (data_addr_lo != 2'h0)) ||        // [RULE_07]
         ((data_size == `XCK_SZ_HALF) && data_addr_lo[0]));                // [RULE_07] [RULE_08]
    // Transfer targets must be word aligned
    assign target_misaligned = target_valid && (target_lo != 2'h0);      // [RULE_09]
endmodule

//--- src/xck_defs.vh
// Constants for the exception checker: register offsets, fields, codes
`ifndef XCK_DEFS_VH
`define XCK_DEFS_VH
// Register byte offsets
`define XCK_REG_CTRL      12'h000
`define XCK_REG_STATUS    12'h004
`define XCK_REG_CLEAR     12'h008
`define XCK_REG_ENABLE    12'h00c
`define XCK_REG_REASON    12'h010
`define XCK_REG_FAULTADDR 12'h014
`define XCK_REG_COUNT     12'h018
// Control bit positions
`define XCK_CTRL_ILL      0
`define XCK_CTRL_DIV      1
`define XCK_CTRL_MIS      2
`define XCK_CTRL_EXTRA    3
`define XCK_CTRL_RESET    4'hf
// Status bits: one per event
`define XCK_EV_ILL        0
`define XCK_EV_DIV        1
`define XCK_EV_MISD       2
`define XCK_EV_MIST       3
`define XCK_EV_W          4
// Reason codes written into the reason field
`define XCK_CODE_NONE     5'h00
`define XCK_CODE_MISD     5'h06
`define XCK_CODE_ILL      5'h05
`define XCK_CODE_MIST     5'h07
`define XCK_CODE_DIV      5'h08
// Access size encodings
`define XCK_SZ_BYTE       2'h0
`define XCK_SZ_HALF       2'h1
`define XCK_SZ_WORD       2'h2
// Divide operands for the signed overflow case
`define XCK_MOST_NEG      32'h80000000
`define XCK_MINUS_ONE     32'hffffffff
`endif

//--- src/xck_div_chk.v
// Divide fault checker: zero divisor and signed overflow
`timescale 1ns/100ps
`include "xck_defs.vh"
module xck_div_chk (
    input  wire        div_valid,
    input  wire        div_signed,
    input  wire [31:0] dividend,
    input  wire [31:0] divisor,
    output wire        div_fault
);
    wire zero_div;
    wire ovf;
    assign zero_div  = (divisor == 32'h00000000);                                // [RULE_04]
    assign ovf       = div_signed && (dividend == `XCK_MOST_NEG) && (divisor == `XCK_MINUS_ONE); // [RULE_05]
    assign div_fault = div_valid && (zero_div || ovf);                           // [RULE_04]
endmodule

//--- src/xck_top.v
// Exception checker top: instruction checks, fault capture, APB registers
//
// Behaviour
// (RULE_01) Undefined opcode or extension raises illegal instruction when that check is on.
// (RULE_02) With MMU or MPU built in, illegal instruction checking is always on.
// (RULE_03) Divide checking exists only with hardware divide; otherwise never raised.
// (RULE_04) Division check flags results unfit for destination: zero divisor, signed overflow.
// (RULE_05) Most negative value divided by minus one raises division error.
// (RULE_06) Misalignment check examines data addresses and transfer targets when on.
// (RULE_07) Word access needs address multiple of four, half-word multiple of two.
// (RULE_08) Byte loads and stores never raise misaligned data exceptions.
// (RULE_09) Jump, call, register jump and return targets must be word aligned.
// (RULE_10) With MMU or MPU built in, misalignment exceptions are always generated.
// (RULE_11) With extra information on, non-break exceptions record a reason code.
// (RULE_12) With MMU or MPU built in, reason recording is always active.
// (RULE_13) Certain exceptions also capture the faulting instruction or data address.
// (RULE_14) A check neither enabled nor forced never traps; instruction completes.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "xck_defs.vh"
module xck_top #(
    parameter HAS_MMU      = 0,
    parameter HAS_MPU      = 0,
    parameter HAS_HW_DIV   = 1,
    parameter CFG_ILL      = 1,
    parameter CFG_DIV      = 1,
    parameter CFG_MIS      = 1,
    parameter CFG_EXTRA    = 1
) (
    input  wire        sys_clk,
    input  wire        srst,
    // Instruction stream from the execute stage
    input  wire        insn_valid,
    input  wire        insn_undefined,
    input  wire        insn_is_break,
    input  wire [31:0] insn_pc,
    // Load/store
    input  wire        mem_valid,
    input  wire [1:0]  mem_size,
    input  wire [31:0] mem_addr,
    // Control transfer
    input  wire        xfer_valid,
    input  wire [31:0] xfer_target,
    // Divide
    input  wire        div_valid,
    input  wire        div_signed,
    input  wire [31:0] div_dividend,
    input  wire [31:0] div_divisor,
    // To the exception sequencer
    output reg         exc_take,
    output reg  [4:0]  exc_reason,
    output reg  [31:0] exc_fault_addr,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire        irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Check enables
    localparam FORCED = (HAS_MMU != 0) || (HAS_MPU != 0);

    reg  [3:0]  ctrl;
    reg  [`XCK_EV_W-1:0] status;
    reg  [`XCK_EV_W-1:0] irq_en;
    reg  [4:0]  reason;
    reg  [31:0] fault_addr;
    reg  [31:0] exc_count;

    wire ill_on;
    wire div_on;
    wire mis_on;
    wire extra_on;

    // Forced on by MMU/MPU, else build option and software enable
    assign ill_on   = FORCED || ((CFG_ILL != 0) && ctrl[`XCK_CTRL_ILL]);                   // [RULE_01] [RULE_02]
    // Divide is not among the forced checks: it needs the divider and its own option
    assign div_on   = (HAS_HW_DIV != 0) && (CFG_DIV != 0) && ctrl[`XCK_CTRL_DIV];          // [RULE_03] [RULE_14]
    assign mis_on   = FORCED || ((CFG_MIS != 0) && ctrl[`XCK_CTRL_MIS]);                   // [RULE_06] [RULE_10]
    assign extra_on = FORCED || ((CFG_EXTRA != 0) && ctrl[`XCK_CTRL_EXTRA]);               // [RULE_11] [RULE_12]

    ////////////////////////////////////////////////////////////////////////////
    // Checkers
    wire raw_misd;
    wire raw_mist;
    wire raw_div;

    xck_align_chk u_align (
        .data_addr_lo      (mem_addr[1:0]),
        .data_size         (mem_size),
        .data_valid        (mem_valid),
        .target_lo         (xfer_target[1:0]),
        .target_valid      (xfer_valid),
        .data_misaligned   (raw_misd),
        .target_misaligned (raw_mist)
    );

    xck_div_chk u_div (
        .div_valid (div_valid),
        .div_signed(div_signed),
        .dividend  (div_dividend),
        .divisor   (div_divisor),
        .div_fault (raw_div)
    );

    // Gated events; a disabled check raises nothing
    wire ev_ill;
    wire ev_div;
    wire ev_misd;
    wire ev_mist;
    wire any_ev;
    assign ev_ill  = insn_valid && insn_undefined && ill_on;   // [RULE_01] [RULE_14]
    assign ev_div  = raw_div && div_on;                        // [RULE_04] [RULE_14]
    assign ev_misd = raw_misd && mis_on;                       // [RULE_06] [RULE_14]
    assign ev_mist = raw_mist && mis_on;                       // [RULE_09] [RULE_14]
    assign any_ev  = ev_ill || ev_div || ev_misd || ev_mist;

    ////////////////////////////////////////////////////////////////////////////
    // Cause selection: illegal first, then divide, data, target
    reg  [4:0]  next_code;
    reg  [31:0] next_addr;
    reg         next_has_addr;
    always @* begin
        next_code     = `XCK_CODE_NONE;
        next_addr     = 32'h00000000;
        next_has_addr = 1'b0;
        if (ev_ill) begin
            next_code     = `XCK_CODE_ILL;
            next_addr     = insn_pc;
        end else if (ev_div) begin
            next_code     = `XCK_CODE_DIV;
        end else if (ev_misd) begin
            next_code     = `XCK_CODE_MISD;
            next_addr     = mem_addr;
            next_has_addr = 1'b1;
        end else if (ev_mist) begin
            next_code     = `XCK_CODE_MIST;
            next_addr     = xfer_target;
            next_has_addr = 1'b1;
        end
    end

    // Exception outputs and recorded cause
    always @(posedge sys_clk) begin
        if (srst) begin
            exc_take       <= 1'b0;
            exc_reason     <= `XCK_CODE_NONE;
            exc_fault_addr <= 32'h00000000;
            reason         <= `XCK_CODE_NONE;
            fault_addr     <= 32'h00000000;
            exc_count      <= 32'h00000000;
        end else begin
            exc_take <= any_ev;
            if (any_ev) begin
                exc_count <= exc_count + 32'h00000001;
                // Break exceptions leave the reason untouched
                if (extra_on && !insn_is_break) begin
                    reason     <= next_code;                   // [RULE_11]
                    exc_reason <= next_code;                   // [RULE_11]
                    if (next_has_addr) begin
                        fault_addr     <= next_addr;           // [RULE_13]
                        exc_fault_addr <= next_addr;           // [RULE_13]
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait, unmapped reads zero with error
    wire apb_wr;
    wire apb_rd;
    wire mapped;
    wire [6:0] reg_sel;

    // One select bit per mapped offset, shared by writes, clears and errors
    function [6:0] reg_dec;
        input [11:0] a;
        begin
            case (a)
                `XCK_REG_CTRL:      reg_dec = 7'h01;
                `XCK_REG_STATUS:    reg_dec = 7'h02;
                `XCK_REG_CLEAR:     reg_dec = 7'h04;
                `XCK_REG_ENABLE:    reg_dec = 7'h08;
                `XCK_REG_REASON:    reg_dec = 7'h10;
                `XCK_REG_FAULTADDR: reg_dec = 7'h20;
                `XCK_REG_COUNT:     reg_dec = 7'h40;
                default:            reg_dec = 7'h00;
            endcase
        end
    endfunction

    assign pready  = 1'b1;
    assign apb_wr  = psel && penable && pwrite;
    assign apb_rd  = psel && !pwrite;
    assign reg_sel = reg_dec(paddr);
    assign mapped  = |reg_sel;
    assign pslverr = psel && penable && !mapped;

    // Control and interrupt enable registers
    always @(posedge sys_clk) begin
        if (srst) begin
            ctrl   <= `XCK_CTRL_RESET;
            irq_en <= {`XCK_EV_W{1'b0}};
        end else if (apb_wr) begin
            if (reg_sel[0])
                ctrl <= pwdata[3:0];
            if (reg_sel[3])
                irq_en <= pwdata[`XCK_EV_W-1:0];
        end
    end

    // Sticky status; a new event wins over a clear in the same cycle
    wire [`XCK_EV_W-1:0] ev_vec;
    wire [`XCK_EV_W-1:0] clr_vec;
    assign ev_vec  = {ev_mist, ev_misd, ev_div, ev_ill};
    assign clr_vec = (apb_wr && reg_sel[2]) ? pwdata[`XCK_EV_W-1:0] : {`XCK_EV_W{1'b0}};
    always @(posedge sys_clk) begin
        if (srst)
            status <= {`XCK_EV_W{1'b0}};
        else
            status <= (status & ~clr_vec) | ev_vec;
    end

    assign irq = |(status & irq_en);

    // Read data registered in the setup phase
    always @(posedge sys_clk) begin
        if (srst) begin
            prdata <= 32'h00000000;
        end else if (apb_rd && !penable) begin
            case (paddr)
                `XCK_REG_CTRL:      prdata <= {28'h0000000, ctrl};
                `XCK_REG_STATUS:    prdata <= {{(32-`XCK_EV_W){1'b0}}, status};
                `XCK_REG_ENABLE:    prdata <= {{(32-`XCK_EV_W){1'b0}}, irq_en};
                `XCK_REG_REASON:    prdata <= {27'h0000000, reason};
                `XCK_REG_FAULTADDR: prdata <= fault_addr;
                `XCK_REG_COUNT:     prdata <= exc_count;
                default:            prdata <= 32'h00000000;
            endcase
        end
    end
endmodule

//--- tb/test_xck_top.sv
// Self-checking bench: random events, APB registers, interrupt
`timescale 1ns/100ps
`include "xck_defs.vh"
module test_xck_top;
    reg         sys_clk, srst, insn_valid, insn_undefined, insn_is_break, mem_valid;
    reg         xfer_valid, div_valid, div_signed, psel, penable, pwrite, err;
    reg  [1:0]  mem_size;
    reg  [11:0] paddr;
    reg  [31:0] insn_pc, mem_addr, xfer_target, div_dividend, div_divisor, pwdata, rd, rdm, r, ea, eam, cnt;
    reg  [3:0]  ctl, st, f, en, stm, fm;
    reg  [4:0]  er, erm;
    wire        exc_take, pready, pslverr, irq, m_take, m_irq;
    wire [4:0]  exc_reason, m_reason;
    wire [31:0] exc_fault_addr, prdata, m_faddr, m_rdata;
    integer     seed, error_cnt, cmp_count, i;
    xck_top u_dut (.*);
    // Second build: MMU present, no hardware divide
    xck_top #(.HAS_MMU(1), .HAS_HW_DIV(0)) u_dut_mmu (.*, .exc_take(m_take), .exc_reason(m_reason),
        .exc_fault_addr(m_faddr), .prdata(m_rdata), .pready(), .pslverr(), .irq(m_irq));
    // Clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt = error_cnt + 1;
        results;
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge sys_clk);
            penable <= 1'b1;
            @(posedge sys_clk);
            while (pready !== 1'b1) @(posedge sys_clk);
            rd = prdata;
            rdm = m_rdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    // Expected faults for effective check enables (bit 0 ill, 1 div, 2 misalign)
    function [3:0] faults(input [3:0] c);
        begin
            faults[0] = insn_valid & insn_undefined & c[0];
            faults[1] = div_valid & c[1] & (div_divisor == 0 | div_signed & div_dividend == `XCK_MOST_NEG
                        & div_divisor == `XCK_MINUS_ONE);
            faults[2] = mem_valid & c[2] & (mem_size == `XCK_SZ_WORD ? mem_addr[1:0] != 0
                        : mem_size == `XCK_SZ_HALF & mem_addr[0]);
            faults[3] = xfer_valid & c[2] & xfer_target[1:0] != 0;
        end
    endfunction
    // Reason code by priority: illegal, divide, data, target
    function [4:0] code(input [3:0] v);
        code = v[0] ? `XCK_CODE_ILL : v[1] ? `XCK_CODE_DIV : v[2] ? `XCK_CODE_MISD : `XCK_CODE_MIST;
    endfunction
    // Only a misalignment that wins the priority replaces the address
    function [31:0] addr(input [3:0] v, input [31:0] old);
        addr = (v[0] | v[1]) ? old : v[2] ? mem_addr : v[3] ? xfer_target : old;
    endfunction
    // One random cycle of events, then the expected record
    task ev;
        begin
            r = $random(seed);
            {xfer_valid, mem_valid, div_valid, insn_valid} <= r[3:0];
            {div_signed, insn_is_break, insn_undefined} <= {r[7], r[5] & r[6], r[4]};
            mem_size <= (r[9:8] == 2'h3) ? `XCK_SZ_WORD : r[9:8];
            mem_addr <= $random(seed);
            xfer_target <= $random(seed);
            insn_pc <= $random(seed);
            div_dividend <= r[10] ? `XCK_MOST_NEG : $random(seed);
            div_divisor <= r[11] ? (r[12] ? 32'h0 : `XCK_MINUS_ONE) : $random(seed);
            @(posedge sys_clk);
            f = faults(ctl);
            fm = faults(4'hd);
            st = st | f;
            stm = stm | fm;
            cnt = cnt + (f != 0);
            if (f != 0 && ctl[3] && !insn_is_break) begin
                er = code(f);
                ea = addr(f, ea);
            end
            if (fm != 0 && !insn_is_break) begin
                erm = code(fm);
                eam = addr(fm, eam);
            end
            {xfer_valid, mem_valid, div_valid, insn_valid} <= 4'h0;
            #1;
            chk(exc_take, f != 0);
            chk(exc_reason, er);
            chk(exc_fault_addr, ea);
            chk(irq, |(st & en));
            chk(m_take, fm != 0);
            chk(m_reason, erm);
            chk(m_faddr, eam);
            chk(m_irq, |(stm & en));
            @(posedge sys_clk);
        end
    endtask
    task results;
        begin
            $display("errors %0d compares %0d", error_cnt, cmp_count);
            if (error_cnt == 0 && cmp_count > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // Main sequence: every control setting with random events
    initial begin
        seed = 46;
        {error_cnt, cmp_count} = 0;
        srst = 1'b1;
        {insn_valid, insn_undefined, insn_is_break, mem_valid, xfer_valid, div_valid, div_signed} = 0;
        {psel, penable, pwrite, paddr, pwdata, mem_size, insn_pc, mem_addr, xfer_target} = 0;
        {div_dividend, div_divisor, st, er, ea, en, stm, erm, eam, cnt} = 0;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        apb(1'b0, `XCK_REG_CTRL, 0);
        chk(rd[3:0], `XCK_CTRL_RESET);
        apb(1'b0, 12'h100, 0);
        chk(err, 1'b1);
        for (i = 0; i < 16; i = i + 1) begin
            ctl = i;
            en = $random(seed);
            apb(1'b1, `XCK_REG_CTRL, {28'h0, ctl});
            apb(1'b1, `XCK_REG_ENABLE, {28'h0, en});
            repeat (24) ev;
            apb(1'b0, `XCK_REG_STATUS, 0);
            chk(rd[3:0], st);
            chk(rdm[3:0], stm);
            apb(1'b0, `XCK_REG_REASON, 0);
            chk(rd[4:0], er);
            chk(rdm[4:0], erm);
            apb(1'b0, `XCK_REG_FAULTADDR, 0);
            chk(rd, ea);
            apb(1'b0, `XCK_REG_COUNT, 0);
            chk(rd, cnt);
            apb(1'b1, `XCK_REG_CLEAR, {28'h0, en});
            st = st & ~en;
            stm = stm & ~en;
            chk(irq, 1'b0);
            chk(m_irq, 1'b0);
        end
        results;
    end
endmodule

//--- tb/xck_top_chk.sv
// Checker for fault flagging and recording of the exception checker
`timescale 1ns/100ps
`include "xck_defs.vh"
module xck_top_chk #(
    parameter HAS_MMU = 0, parameter HAS_MPU = 0, parameter HAS_HW_DIV = 1,
    parameter CFG_ILL = 1, parameter CFG_DIV = 1, parameter CFG_MIS = 1, parameter CFG_EXTRA = 1
) (
    input wire        sys_clk,
    input wire        srst,
    input wire        insn_valid,
    input wire        insn_undefined,
    input wire        insn_is_break,
    input wire        mem_valid,
    input wire [1:0]  mem_size,
    input wire [31:0] mem_addr,
    input wire        xfer_valid,
    input wire [31:0] xfer_target,
    input wire        div_valid,
    input wire        div_signed,
    input wire [31:0] div_dividend,
    input wire [31:0] div_divisor,
    input wire        exc_take,
    input wire [4:0]  exc_reason,
    input wire [31:0] exc_fault_addr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    reg [3:0] ctl;
    // Shadow of the control register
    always @(posedge sys_clk) begin
        if (srst)
            ctl <= `XCK_CTRL_RESET;
        else if (psel && penable && pwrite && paddr == `XCK_REG_CTRL)
            ctl <= pwdata[3:0];
    end
    // Fault conditions seen this cycle
    wire mmu = HAS_MMU != 0 || HAS_MPU != 0;
    wire f_ill = insn_valid && insn_undefined && (mmu || (CFG_ILL != 0 && ctl[0]));
    wire f_div = div_valid && HAS_HW_DIV != 0 && CFG_DIV != 0 && ctl[1] && (div_divisor == 32'h0
                 || (div_signed && div_dividend == `XCK_MOST_NEG && div_divisor == `XCK_MINUS_ONE));
    wire en_mis = mmu || (CFG_MIS != 0 && ctl[2]);
    wire f_md = mem_valid && en_mis && ((mem_size == `XCK_SZ_WORD && mem_addr[1:0] != 2'h0)
                || (mem_size == `XCK_SZ_HALF && mem_addr[0]));
    wire f_mt = xfer_valid && en_mis && xfer_target[1:0] != 2'h0;
    wire rec = !insn_is_break && (mmu || (CFG_EXTRA != 0 && ctl[3]));
    wire any = f_ill || f_div || f_md || f_mt;
    sequence s_md; !f_ill && !f_div && f_md && rec; endsequence
    sequence s_mt; !f_ill && !f_div && !f_md && f_mt && rec; endsequence
    property p_take; any |=> exc_take; endproperty
    property p_quiet; !any |=> !exc_take; endproperty
    property p_ill; f_ill && rec |=> exc_reason == `XCK_CODE_ILL; endproperty
    property p_div; !f_ill && f_div && rec |=> exc_reason == `XCK_CODE_DIV; endproperty
    property p_md; s_md |=> exc_reason == `XCK_CODE_MISD && exc_fault_addr == $past(mem_addr); endproperty
    property p_mt; s_mt |=> exc_reason == `XCK_CODE_MIST && exc_fault_addr == $past(xfer_target); endproperty
    property p_byte; mem_valid && mem_size == `XCK_SZ_BYTE && !insn_valid && !div_valid && !xfer_valid
        |=> !exc_take; endproperty
    property p_hold; !(any && rec) |=> $stable(exc_reason); endproperty
    a_take: assert property (p_take) else $error("fault not taken");
    a_quiet: assert property (p_quiet) else $error("take without fault");
    a_ill: assert property (p_ill) else $error("bad illegal code");
    a_div: assert property (p_div) else $error("bad divide code");
    a_md: assert property (p_md) else $error("bad data misalign record");
    a_mt: assert property (p_mt) else $error("bad target misalign record");
    a_byte: assert property (p_byte) else $error("byte access trapped");
    a_hold: assert property (p_hold) else $error("reason changed");
endmodule
bind xck_top xck_top_chk #(.HAS_MMU(HAS_MMU), .HAS_MPU(HAS_MPU), .HAS_HW_DIV(HAS_HW_DIV), .CFG_ILL(CFG_ILL),
    .CFG_DIV(CFG_DIV), .CFG_MIS(CFG_MIS), .CFG_EXTRA(CFG_EXTRA)) u_chk (.*);
